// File: bench/fsx_exception_unit_asserts.sv
// assertions on the ports of the float status and exception unit
`timescale 1ns/1ps
`default_nettype none
module fsx_exception_unit_asserts
   import fsx_pkg::*;
#(parameter int ADDR_W = 16)(
   input wire logic              sys_clk, rst_n, clk_en, load_status_valid, op_valid,
   input wire fsx_pkg::fsx_op_t  op_class,
   input wire logic              op_illegal, res_div_zero, res_overflow, res_underflow,
   input wire logic [2:0]        op_src_reg, op_ac,
   input wire logic [15:0]       operand_hi, float_status_control,
   input wire logic [ADDR_W-1:0] xfer_base, xfer_addr,
   input wire logic [1:0]        xfer_index,
   input wire logic [3:0]        float_exception_code, addr_step,
   input wire logic [8:0]        int_vector,
   input wire logic [6:0]        int_width,
   input wire logic              int_req, result_exact_zero, double_precision_select,
   input wire logic              long_integer_select, chop_select
);
   logic [1:0]  up_q;
   logic [15:0] fsc;
   assign fsc = float_status_control;
   // edges since release; the unit leaves reset on the second one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // an operation report taken once the unit is out of reset
   sequence s_taken;
      op_valid && clk_en && up_q == 2'h3;
   endsequence
   // a plain arithmetic report with no other exception and no status load
   sequence s_clean;
      s_taken ##0 (!op_illegal && !res_div_zero && !operand_hi[15] && op_src_reg < 3'h6
         && !op_ac[2] && op_class == fsx_op_arith && !load_status_valid);
   endsequence
   a_vector_fixed: assert property (int_vector == 9'h0a4)
      else $error("interrupt vector is not 244 octal");
   a_err_sticky: assert property (fsc[15] && !(load_status_valid && clk_en) |=> fsc[15])
      else $error("error flag cleared without a status load");
   a_code_with_err: assert property (!$stable(float_exception_code) |-> fsc[15])
      else $error("exception code changed without the error flag");
   a_illegal_code: assert property (s_taken ##0 op_illegal |=> float_exception_code == 4'h2 && fsc[15])
      else $error("illegal opcode not coded as 2");
   a_disable_quiet: assert property (fsc[14] && !int_req && !(load_status_valid && clk_en) |=> !int_req)
      else $error("interrupt raised under global disable");
   a_mode_decode: assert property (
      addr_step == (fsc[7] ? 4'h8 : 4'h4) && int_width == (fsc[6] ? 7'h20 : 7'h10)
      && chop_select == fsc[5] && double_precision_select == fsc[7] && long_integer_select == fsc[6])
      else $error("mode outputs disagree with the status word");
   a_xfer_addr: assert property (up_q == 2'h3 && clk_en |=> xfer_addr == $past(xfer_base) + ADDR_W'({$past(xfer_index), 1'b0}))
      else $error("transfer address is not base plus two per word");
   a_ovf_zero: assert property (s_clean ##0 (res_overflow && !fsc[9]) |=> result_exact_zero)
      else $error("disabled overflow did not store exact zero");
   a_unf_zero: assert property (s_clean ##0 (res_underflow && !res_overflow && !fsc[10]) |=> result_exact_zero)
      else $error("disabled underflow did not store exact zero");
endmodule // fsx_exception_unit_asserts
bind fsx_exception_unit fsx_exception_unit_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// File: bench/fsx_exception_unit_bench.sv
// self-checking bench of the float status and exception unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, v); end end
module fsx_exception_unit_bench;
   import fsx_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0;
   logic        clk_en, bus_reset, load_status_valid, op_valid, op_illegal, int_ack, conv_carry;
   logic        res_negative, res_zero, res_div_zero, res_overflow, res_underflow;
   logic [15:0] load_status_data, operand_hi, res_hi, float_status_control, op_addr;
   logic [15:0] xfer_base, float_exception_address, xfer_addr;
   fsx_op_t     op_class;
   logic [2:0]  op_mode, op_src_reg, op_ac;
   logic [9:0]  res_exp_wide;
   logic [6:0]  conv_bits, int_width;
   logic [1:0]  xfer_index;
   logic [3:0]  float_exception_code, addr_step;
   logic [8:0]  int_vector;
   logic [7:0]  stored_exp;
   logic        int_req, op_done, op_abort, dest_zero, result_exact_zero;
   logic        double_precision_select, long_integer_select, chop_select;
   int          num_errors = 0, comparisons = 0;
   logic [7:0]  ft [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h80, 8'h00};
   logic [3:0]  ec [6] = '{4'h2, 4'h4, 4'h8, 4'ha, 4'h6, 4'hc};
   fsx_exception_unit dut (.*);
   fsx_host_model host (.*);
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   // counts and verdict
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog well beyond the hundred or so cycles of the run
   initial begin
      #100us;
      num_errors++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("status", 16'h0000, float_status_control)
      `CHK("vector", 9'h0a4, int_vector)
      `CHK("step", 4'h4, addr_step)
      `CHK("width", 7'h10, int_width)
      host.load(16'hffff);
      `CHK("status", 16'hcfef, float_status_control)
      `CHK("modes", 3'h7, {double_precision_select, long_integer_select, chop_select})
      `CHK("step", 4'h8, addr_step)
      `CHK("width", 7'h20, int_width)
      host.load(16'h0000);
      `CHK("status", 16'h0000, float_status_control)
      // each exception with all four enables set
      for (int i = 0; i < 6; i++) begin
         host.load(16'h0f00);
         host.op(i == 4 ? fsx_op_to_int : fsx_op_arith, 3'h2, 3'h1,
                 i == 5 ? 16'h8000 : 16'h4080, ft[i], 16'h2000 + 16'(i));
         `CHK("code", ec[i], float_exception_code)
         `CHK("error", 1'b1, float_status_control[15])
         `CHK("address", 16'h2000 + 16'(i), float_exception_address)
         `CHK("dest", i == 4, dest_zero)
         `CHK("int", 1'b1, int_req)
         host.pulse(1'b0);
         `CHK("ack", 1'b0, int_req)
      end
      // disabled overflow, underflow and conversion failure stay silent
      host.load(16'h0000);
      for (int i = 2; i < 5; i++) begin
         host.op(i == 4 ? fsx_op_to_int : fsx_op_arith, 3'h2, 3'h1, 16'h4080, ft[i], 16'h3000);
         `CHK("zeroed", 1'b1, i == 4 ? dest_zero : result_exact_zero)
         `CHK("zflag", 1'b1, float_status_control[2])
         `CHK("error", 1'b0, float_status_control[15])
         `CHK("code", 4'hc, float_exception_code)
         `CHK("int", 1'b0, int_req)
      end
      // condition flags: negative, zero, conversion carry
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h04, 16'h3100);
      `CHK("flags", 4'h8, float_status_control[3:0])
      host.op(fsx_op_arith, 3'h0, 3'h1, 16'h4080, 8'h02, 16'h3102);
      `CHK("flags", 4'h4, float_status_control[3:0])
      host.op(fsx_op_to_int, 3'h2, 3'h1, 16'h4080, 8'h01, 16'h3104);
      `CHK("flags", 4'h1, float_status_control[3:0])
      // undefined value: accumulator ignored, memory traps, bus reset keeps the flag
      host.load(16'h0800);
      host.op(fsx_op_arith, 3'h0, 3'h1, 16'h8000, 8'h00, 16'h4000);
      `CHK("abort", 1'b0, op_abort)
      `CHK("error", 1'b0, float_status_control[15])
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h807f, 8'h00, 16'h4002);
      `CHK("abort", 1'b1, op_abort)
      `CHK("code", 4'hc, float_exception_code)
      `CHK("address", 16'h4002, float_exception_address)
      `CHK("int", 1'b1, int_req)
      host.pulse(1'b1);
      `CHK("int", 1'b0, int_req)
      `CHK("error", 1'b1, float_status_control[15])
      // negate-class check runs after execution and stores exact zero
      host.op(fsx_op_postchk, 3'h2, 3'h1, 16'h8000, 8'h00, 16'h4004);
      `CHK("zeroed", 1'b1, result_exact_zero)
      `CHK("int", 1'b1, int_req)
      host.pulse(1'b0);
      // accumulator 6 in mode 0 is an illegal opcode
      host.op(fsx_op_arith, 3'h0, 3'h6, 16'h4080, 8'h00, 16'h4006);
      `CHK("code", 4'h2, float_exception_code)
      host.pulse(1'b0);
      // global disable: divide by zero still flags and codes
      host.load(16'h4000);
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h20, 16'h4008);
      `CHK("code", 4'h4, float_exception_code)
      `CHK("error", 1'b1, float_status_control[15])
      `CHK("int", 1'b0, int_req)
      // enabled range errors keep wrapped exponents; a silent -0 result becomes exact zero
      host.load(16'h0600);
      host.extra(1'b1, 3'h0, 16'h8000, 10'h105);
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h10, 16'h5000);
      `CHK("exp", 8'h05, stored_exp)
      `CHK("zeroed", 1'b0, result_exact_zero)
      host.extra(1'b1, 3'h0, 16'h8000, 10'h3f0);
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h08, 16'h5002);
      `CHK("exp", 8'hf0, stored_exp)
      `CHK("code", 4'ha, float_exception_code)
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h00, 16'h5004);
      `CHK("zeroed", 1'b1, result_exact_zero)
      `CHK("exp", 8'h00, stored_exp)
      // accumulator field above 3 is illegal in memory modes
      host.extra(1'b1, 3'h4, 16'h0000, 10'h000);
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h00, 16'h5006);
      `CHK("code", 4'h2, float_exception_code)
      `CHK("done", 2'h3, {op_done, op_abort})
      host.pulse(1'b0);
      // with the clock enable low a divide by zero report leaves no trace
      host.extra(1'b0, 3'h0, 16'h0000, 10'h000);
      host.op(fsx_op_arith, 3'h2, 3'h1, 16'h4080, 8'h20, 16'h5008);
      `CHK("frozen", 17'h05006, {op_done, float_exception_address})
      `CHK("code", 4'h2, float_exception_code)
      host.extra(1'b1, 3'h0, 16'h0000, 10'h000);
      // word 3 of a transfer sits six bytes above the base
      host.xfer(16'h0100, 2'h3);
      `CHK("xfer", 16'h0106, xfer_addr)
      end_of_test();
   end
endmodule // fsx_exception_unit_bench
`default_nettype wire

// File: bench/fsx_host_model.sv
// host processor model issuing float operation reports
`timescale 1ns/1ps
`default_nettype none
module fsx_host_model
   import fsx_pkg::*;
#(parameter int ADDR_W = 16)(
   input wire logic          sys_clk,
   output logic              clk_en, bus_reset, load_status_valid, op_valid, op_illegal, int_ack,
   output logic [15:0]       load_status_data, operand_hi, res_hi,
   output fsx_pkg::fsx_op_t  op_class,
   output logic [ADDR_W-1:0] op_addr, xfer_base,
   output logic [2:0]        op_mode, op_src_reg, op_ac,
   output logic              res_negative, res_zero, res_div_zero, res_overflow, res_underflow,
   output logic [9:0]        res_exp_wide,
   output logic [6:0]        conv_bits,
   output logic              conv_carry,
   output logic [1:0]        xfer_index
);
   // quiet host at time zero
   initial begin
      {bus_reset, load_status_valid, op_valid, op_illegal, int_ack, conv_carry} = '0;
      {res_negative, res_zero, res_div_zero, res_overflow, res_underflow} = '0;
      {load_status_data, operand_hi, res_hi, op_addr, xfer_base} = '0;
      {op_mode, op_src_reg, op_ac, res_exp_wide, conv_bits, xfer_index} = '0;
      op_class = fsx_op_other;
      clk_en = 1'b1;
   end
   // load a status word; it shows after the next edge
   task automatic load(input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      load_status_valid = 1'b1;
      load_status_data = d;
      @(posedge sys_clk);
      #1;
      load_status_valid = 1'b0;
   endtask
   // one report; f is {conv fail, illegal, div0, ovf, unf, neg, zero, carry}
   task automatic op(input fsx_op_t c, input logic [2:0] m, s, input logic [15:0] w,
                     input logic [7:0] f, input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      #1;
      op_valid = 1'b1;
      op_class = c;
      op_mode = m;
      op_src_reg = s;
      operand_hi = w;
      op_addr = a;
      conv_bits = f[7] ? 7'h11 : 7'h08;
      {op_illegal, res_div_zero, res_overflow, res_underflow} = f[6:3];
      {res_negative, res_zero, conv_carry} = f[2:0];
      @(posedge sys_clk);
      #1;
      op_valid = 1'b0;
      operand_hi = ~w;
      op_addr = ~a;
   endtask
   // single-cycle bus reset (b=1) or interrupt acknowledge (b=0)
   task automatic pulse(input logic b);
      @(posedge sys_clk);
      #1;
      bus_reset = b;
      int_ack = !b;
      @(posedge sys_clk);
      #1;
      {bus_reset, int_ack} = 2'b00;
   endtask
   // present a transfer base and word index for one edge
   task automatic xfer(input logic [ADDR_W-1:0] b, input logic [1:0] i);
      @(posedge sys_clk);
      #1;
      xfer_base = b;
      xfer_index = i;
      @(posedge sys_clk);
      #1;
   endtask
   // side inputs: clock enable, accumulator field, raw result word and wide exponent
   task automatic extra(input logic e, input logic [2:0] a, input logic [15:0] h,
                        input logic [9:0] x);
      {clk_en, op_ac, res_hi, res_exp_wide} = {e, a, h, x};
   endtask
endmodule // fsx_host_model
`default_nettype wire

// File: core/fsx_defs.svh
// constants of the float status and exception unit
`ifndef FSX_DEFS_SVH
`define FSX_DEFS_SVH

// status and control word bit positions
`define FSX_ERR_BIT        15
`define FSX_DIS_BIT        14
`define FSX_UV_EN_BIT      11
`define FSX_UF_EN_BIT      10
`define FSX_OV_EN_BIT      9
`define FSX_CV_EN_BIT      8
`define FSX_DBL_BIT        7
`define FSX_LONG_BIT       6
`define FSX_CHOP_BIT       5
`define FSX_NEG_BIT        3
`define FSX_ZERO_BIT       2
`define FSX_OVF_BIT        1
`define FSX_CARRY_BIT      0

// writable bits: 13, 12 and 4 are reserved and read as zero
`define FSX_STATUS_WMASK   16'hcfef
`define FSX_STATUS_RST     16'h0000

// exception codes
`define FSX_EC_RST         4'h0
`define FSX_EC_ILLEGAL     4'h2
`define FSX_EC_DIVZ        4'h4
`define FSX_EC_CONV        4'h6
`define FSX_EC_OVF         4'h8
`define FSX_EC_UNF         4'ha
`define FSX_EC_UNDEF       4'hc

// shared interrupt vector, octal 244
`define FSX_INT_VECTOR     9'h0a4

// address steps for autoincrement and autodecrement, octal 4 and 10
`define FSX_STEP_SINGLE    4'h4
`define FSX_STEP_DOUBLE    4'h8

// integer widths used by conversions
`define FSX_INT_W_SHORT    7'h10
`define FSX_INT_W_LONG     7'h20

// highest legal accumulator numbers
`define FSX_MAX_AC_REG     3'h5
`define FSX_MAX_AC_MEM     3'h3

// first word of a floating value: sign and biased exponent field
`define FSX_SIGN_BIT       15
`define FSX_EXP_HI         14
`define FSX_EXP_LO         7

`endif

// File: core/fsx_exception_unit.sv
// float status, mode and exception unit
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// [RULE_01] six exceptions coded 2 to 12
// [RULE_02] all exceptions share vector octal 244
// [RULE_03] error flag set on div0, illegal, enabled
// [RULE_04] only status load clears error flag
// [RULE_05] global disable suppresses every float interrupt
// [RULE_06] memory -0 operand traps when enabled
// [RULE_07] accumulator -0 never traps; else usable
// [RULE_08] -0 stored only with an interrupt
// [RULE_09] enabled underflow interrupts, exponent kept wrapped
// [RULE_10] disabled underflow stores exact zero silently
// [RULE_11] overflow interrupts or stores exact zero
// [RULE_12] failed conversion zeroes destination, optional interrupt
// [RULE_13] bit 7 selects double precision
// [RULE_14] bit 6 selects 32-bit integers
// [RULE_15] bit 5 selects chop instead of round
// [RULE_16] negative, zero, overflow flags follow result
// [RULE_17] carry only on conversion carry out
// [RULE_18] code and address update with error
// [RULE_19] code and address have no write path
// [RULE_20] mode 0 uses accumulators 0 to 5
// [RULE_21] address step 4 single, 8 double
// [RULE_22] most significant word at lowest address
// [RULE_23] -0 is sign one, exponent zero
module fsx_exception_unit
   import fsx_pkg::*;
#(
   parameter int ADDR_W = 16
)(
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   input  wire logic                    bus_reset,
   input  wire logic                    load_status_valid,
   input  wire logic             [15:0] load_status_data,
   input  wire logic                    op_valid,
   input  wire fsx_pkg::fsx_op_t        op_class,
   input  wire logic             [ADDR_W-1:0] op_addr,
   input  wire logic             [2:0]  op_mode,
   input  wire logic             [2:0]  op_src_reg,
   input  wire logic             [2:0]  op_ac,
   input  wire logic                    op_illegal,
   input  wire logic             [15:0] operand_hi,
   input  wire logic                    res_negative,
   input  wire logic                    res_zero,
   input  wire logic                    res_div_zero,
   input  wire logic                    res_overflow,
   input  wire logic                    res_underflow,
   input  wire logic             [15:0] res_hi,
   input  wire logic             [9:0]  res_exp_wide,
   input  wire logic             [6:0]  conv_bits,
   input  wire logic                    conv_carry,
   input  wire logic             [ADDR_W-1:0] xfer_base,
   input  wire logic             [1:0]  xfer_index,
   input  wire logic                    int_ack,
   output logic                  [15:0] float_status_control,
   output logic                  [3:0]  float_exception_code,
   output logic                  [ADDR_W-1:0] float_exception_address,
   output logic                         int_req,
   output logic                  [8:0]  int_vector,
   output logic                         op_done,
   output logic                         op_abort,
   output logic                         dest_zero,
   output logic                         result_exact_zero,
   output logic                  [7:0]  stored_exp,
   output logic                  [ADDR_W-1:0] xfer_addr,
   output logic                  [3:0]  addr_step,
   output logic                  [6:0]  int_width,
   output logic                         double_precision_select,
   output logic                         long_integer_select,
   output logic                         chop_select
);
   `include "fsx_defs.svh"

   // all registered state of the unit apart from the reset synchronizer
   typedef struct packed {
      logic [15:0]       status;
      logic [3:0]        exc_code;
      logic [ADDR_W-1:0] exc_addr;
      logic              int_pend;
      logic              done;
      logic              abort;
      logic              dest_zero;
      logic              exact_zero;
      logic [7:0]        exp;
      logic [ADDR_W-1:0] xfer_addr;
   } fsx_state_t;

   fsx_state_t state_q;
   fsx_state_t state_d;

   logic [1:0] rst_sync_q;
   logic       rst_int_n;

   logic       sel_illegal;
   logic       undef_hit;
   logic       undef_after;

   logic       illegal;
   logic       undef_before;
   logic       undef_late;
   logic       executes;
   logic       div_zero;
   logic       overflow;
   logic       underflow;
   logic       conv_fail;
   logic       err_event;
   logic       raise_int;
   logic       exact_zero;
   logic [3:0] code;

   // release of the asynchronous reset through two flip-flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_q[1];

   // accumulator legality and undefined operand detection
   fsx_operand_check u_check (
      .op_mode     (op_mode),
      .op_src_reg  (op_src_reg),
      .op_ac       (op_ac),
      .op_class    (op_class),
      .operand_hi  (operand_hi),
      .undef_en    (state_q.status[`FSX_UV_EN_BIT]),
      .sel_illegal (sel_illegal),
      .undef_hit   (undef_hit),
      .undef_after (undef_after)
   );

   // classify the reported operation
   always_comb begin
      illegal      = op_valid && (op_illegal || sel_illegal); // [RULE_20]
      undef_before = op_valid && !illegal && undef_hit && !undef_after; // [RULE_06]
      executes     = op_valid && !illegal && !undef_before;
      undef_late   = executes && undef_hit && undef_after; // [RULE_06]
      div_zero     = executes && res_div_zero;
      overflow     = executes && res_overflow;
      underflow    = executes && res_underflow;
      // conversion fails when the integer needs more bits than the width allows
      conv_fail    = executes && (op_class == fsx_op_to_int) &&
                     (conv_bits > int_width); // [RULE_12] [RULE_14]
   end

   // exception code, first cause wins
   always_comb begin
      code = `FSX_EC_RST;
      if (illegal) begin
         code = `FSX_EC_ILLEGAL; // [RULE_01]
      end else if (undef_before || undef_late) begin
         code = `FSX_EC_UNDEF; // [RULE_01]
      end else if (div_zero) begin
         code = `FSX_EC_DIVZ; // [RULE_01]
      end else if (conv_fail && state_q.status[`FSX_CV_EN_BIT]) begin
         code = `FSX_EC_CONV; // [RULE_01]
      end else if (overflow && state_q.status[`FSX_OV_EN_BIT]) begin
         code = `FSX_EC_OVF; // [RULE_01]
      end else if (underflow && state_q.status[`FSX_UF_EN_BIT]) begin
         code = `FSX_EC_UNF; // [RULE_01]
      end
   end

   // error event and the interrupt it may raise
   always_comb begin
      err_event = illegal || div_zero || undef_before || undef_late ||
                  (conv_fail && state_q.status[`FSX_CV_EN_BIT]) ||
                  (overflow && state_q.status[`FSX_OV_EN_BIT]) ||
                  (underflow && state_q.status[`FSX_UF_EN_BIT]); // [RULE_03]
      raise_int = err_event && !state_q.status[`FSX_DIS_BIT]; // [RULE_05]
      // disabled range errors, post-checked -0 and any silent -0 become exact zero
      exact_zero = (overflow && !state_q.status[`FSX_OV_EN_BIT]) || // [RULE_11]
                   (underflow && !state_q.status[`FSX_UF_EN_BIT]) || // [RULE_10]
                   undef_late ||
                   (executes && fsx_is_neg_zero(res_hi) && !raise_int); // [RULE_08] [RULE_23]
   end

   // next state
   always_comb begin
      state_d = state_q;
      state_d.done       = 1'b0;
      state_d.abort      = 1'b0;
      state_d.dest_zero  = 1'b0;
      state_d.exact_zero = 1'b0;

      // status load writes mode, enables, flags and the error flag from the loaded word
      if (load_status_valid) begin
         state_d.status = load_status_data & `FSX_STATUS_WMASK; // [RULE_04] [RULE_19]
      end

      if (op_valid) begin
         state_d.done  = 1'b1;
         state_d.abort = illegal || undef_before; // [RULE_06]
      end

      // result side effects of an executed operation
      if (executes) begin
         state_d.dest_zero  = conv_fail; // [RULE_12]
         state_d.exact_zero = exact_zero || conv_fail;
         // enabled range errors keep the low eight exponent bits, off by octal 400
         state_d.exp = exact_zero ? 8'h00 : res_exp_wide[7:0]; // [RULE_09] [RULE_11]
         state_d.status[`FSX_NEG_BIT]  = res_negative && !exact_zero && !conv_fail; // [RULE_16]
         state_d.status[`FSX_ZERO_BIT] = res_zero || exact_zero || conv_fail; // [RULE_16]
         state_d.status[`FSX_OVF_BIT]  = overflow; // [RULE_16]
         state_d.status[`FSX_CARRY_BIT] = (op_class == fsx_op_to_int) &&
                                          conv_carry; // [RULE_17]
      end

      // error flag is set by hardware or by a status load; a set beats a load clear
      if (err_event) begin
         state_d.status[`FSX_ERR_BIT] = 1'b1; // [RULE_03] [RULE_04]
         // code and address follow the error even when interrupts are disabled
         state_d.exc_code = code; // [RULE_18]
         state_d.exc_addr = op_addr; // [RULE_18]
      end

      // interrupt request stands until acknowledged or bus reset
      if (int_ack || bus_reset) begin
         state_d.int_pend = 1'b0;
      end
      if (raise_int) begin
         state_d.int_pend = 1'b1; // [RULE_05]
      end

      // memory word address: word 0 is the most significant, lowest address
      state_d.xfer_addr = xfer_base + ADDR_W'({xfer_index, 1'b0}); // [RULE_22]
   end

   // state register; clock enable freezes everything
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state_q.status     <= `FSX_STATUS_RST;
         state_q.exc_code   <= `FSX_EC_RST;
         state_q.exc_addr   <= '0;
         state_q.int_pend   <= 1'b0;
         state_q.done       <= 1'b0;
         state_q.abort      <= 1'b0;
         state_q.dest_zero  <= 1'b0;
         state_q.exact_zero <= 1'b0;
         state_q.exp        <= 8'h00;
         state_q.xfer_addr  <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // register views
   assign float_status_control    = state_q.status;
   assign float_exception_code    = state_q.exc_code; // [RULE_19]
   assign float_exception_address = state_q.exc_addr; // [RULE_19]
   assign int_req                 = state_q.int_pend;
   assign int_vector              = `FSX_INT_VECTOR; // [RULE_02]
   assign op_done                 = state_q.done;
   assign op_abort                = state_q.abort;
   assign dest_zero               = state_q.dest_zero;
   assign result_exact_zero       = state_q.exact_zero;
   assign stored_exp              = state_q.exp;
   assign xfer_addr               = state_q.xfer_addr;

   // mode selects driven from the status word
   assign double_precision_select = state_q.status[`FSX_DBL_BIT]; // [RULE_13]
   assign long_integer_select     = state_q.status[`FSX_LONG_BIT]; // [RULE_14]
   assign chop_select             = state_q.status[`FSX_CHOP_BIT]; // [RULE_15]
   assign addr_step = state_q.status[`FSX_DBL_BIT] ? `FSX_STEP_DOUBLE
                                                   : `FSX_STEP_SINGLE; // [RULE_21]
   assign int_width = state_q.status[`FSX_LONG_BIT] ? `FSX_INT_W_LONG
                                                    : `FSX_INT_W_SHORT; // [RULE_14]
endmodule // fsx_exception_unit
`default_nettype wire

// File: core/fsx_operand_check.sv
// operand legality and undefined-value detection
`timescale 1ns/1ps
`default_nettype none
module fsx_operand_check
   import fsx_pkg::*;
(
   input  wire logic             [2:0]  op_mode,
   input  wire logic             [2:0]  op_src_reg,
   input  wire logic             [2:0]  op_ac,
   input  wire fsx_pkg::fsx_op_t        op_class,
   input  wire logic             [15:0] operand_hi,
   input  wire logic                    undef_en,
   output logic                         sel_illegal,
   output logic                         undef_hit,
   output logic                         undef_after
);
   `include "fsx_defs.svh"

   logic mem_mode;
   logic class_checked;

   // mode 0 takes an accumulator, every other mode touches memory or registers
   assign mem_mode = (op_mode != 3'h0);

   // accumulators 6 and 7 only exist as illegal codes in mode 0
   assign sel_illegal = (!mem_mode && (op_src_reg > `FSX_MAX_AC_REG)) ||
                        (op_ac > `FSX_MAX_AC_MEM); // [RULE_20]

   // arithmetic, compare, modulo, load and the post-checked group look at operands
   assign class_checked = (op_class == fsx_op_arith) || (op_class == fsx_op_load) ||
                          (op_class == fsx_op_postchk);

   // only memory operands trap; an accumulator holding -0 never does
   assign undef_hit = undef_en && mem_mode && class_checked &&
                      fsx_is_neg_zero(operand_hi); // [RULE_06] [RULE_07] [RULE_23]

   // negate, absolute and test trap after the result is written
   assign undef_after = (op_class == fsx_op_postchk); // [RULE_06]
endmodule // fsx_operand_check
`default_nettype wire

// File: core/fsx_pkg.sv
// types and shared decode of the float status and exception unit
package fsx_pkg;
   `include "fsx_defs.svh"

   // class of the operation being reported by the host
   typedef enum logic [2:0] {
      fsx_op_other,
      fsx_op_arith,
      fsx_op_load,
      fsx_op_postchk,
      fsx_op_to_int
   } fsx_op_t;

   // sign set and biased exponent zero marks an undefined value
   function automatic logic fsx_is_neg_zero(input logic [15:0] word);
      fsx_is_neg_zero = word[`FSX_SIGN_BIT] &&
                        (word[`FSX_EXP_HI:`FSX_EXP_LO] == 8'h00);
   endfunction
endpackage
